// File: logic/multiqueue_almost_flag_logic.sv
// almost-full and almost-empty flag logic of one multi-queue device
// assumes selections and strobes synchronous to core_clk, one host
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "almost_flag_map.svh"

module multiqueue_almost_flag_logic #(
   parameter int NQ    = 4,
   parameter int DEPTH = 4096
) (
   input  wire logic                 core_clk,            // 10 MHz clock
   input  wire logic                 resetn,              // sync reset
   input  wire logic                 cyc_i,               // wishbone cycle
   input  wire logic                 stb_i,               // wishbone strobe
   input  wire logic                 we_i,                // wishbone write
   input  wire logic [7:0]           adr_i,               // byte address
   input  wire logic [3:0]           sel_i,               // byte lanes
   input  wire logic [31:0]          dat_i,               // write data
   output logic      [31:0]          dat_o,               // read data
   output logic                      ack_o,               // wishbone ack
   output logic                      irq,                 // level interrupt
   input  wire almost_flag_pkg::dev_t deviceId,           // own device number
   input  wire logic                 flagBusExpansionIn,  // low on master
   output logic                      flagBusExpansionOut, // unused by system
   input  wire almost_flag_pkg::sel_s wrSel,              // write port select
   input  wire almost_flag_pkg::sel_s rdSel,              // read port select
   input  wire almost_flag_pkg::sel_s afBusSel,           // full bus select
   input  wire almost_flag_pkg::sel_s aeBusSel,           // empty bus select
   input  wire logic                 wrEn,                // write strobe
   input  wire logic                 rdEn,                // read strobe
   output logic                      almostFullFlagN,     // discrete, low=on
   output logic                      almostFullFlagOe,    // drive enable
   output logic                      almostEmptyFlagN,    // discrete, low=on
   output logic                      almostEmptyFlagOe,   // drive enable
   output logic                      readDataOe,          // data bus enable
   output logic      [NQ-1:0]        almostFullStatusBusN,  // per queue
   output logic                      almostFullStatusBusOe, // drive enable
   output logic      [NQ-1:0]        almostEmptyStatusBusN, // per queue
   output logic                      almostEmptyStatusBusOe // drive enable
);
   import almost_flag_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // assert follows the two-cycle delayed level; release needs the
   // raw level too, unless the skew penalty adds the second cycle
   function automatic logic [NQ-1:0] nextStat(input logic [NQ-1:0] raw,
                                              input logic [NQ-1:0] d1,
                                              input logic          skew);
      nextStat = d1 & (raw | {NQ{skew}});
   endfunction : nextStat

   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
      for (int b = 0; b < 4; b++) begin
         laneMerge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
      end
   endfunction : laneMerge

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic              skew_q;
   logic [15:0]       fullLvl_q;
   logic [15:0]       emptyLvl_q;
   logic [7:0]        iStat_q;
   logic [7:0]        iMask_q;
   logic              ack_q;
   logic [31:0]       rdData_q;
   logic              wbWr;
   logic              wbRd;
   logic [31:0]       wrWord, fullMerge, emptyMerge;

   assign wbWr   = cyc_i & stb_i & we_i & ~ack_q;
   assign wbRd   = cyc_i & stb_i & ~we_i & ~ack_q;
   assign wrWord = laneMerge(32'h0, dat_i, sel_i);
   assign fullMerge  = laneMerge({16'h0, fullLvl_q}, dat_i, sel_i);
   assign emptyMerge = laneMerge({16'h0, emptyLvl_q}, dat_i, sel_i);

   // selection state
   sel_s              wrSelD_q, rdSelD_q, afSelD_q, aeSelD_q;
   logic              wrOwn_q, rdOwn_q;
   queue_t            wrQ_q, wrQ2_q, rdQ_q, rdQ2_q;
   logic              afBusOwn_q, aeBusOwn_q;

   // per-queue fill and flag pipeline
   logic [CW-1:0]     fill_q [NQ];
   logic [NQ-1:0]     afRaw, aeRaw;
   logic [NQ-1:0]     afD1_q, aeD1_q;
   logic [NQ-1:0]     afStat_q, aeStat_q;
   logic [CW-1:0]     fullLimit;
   logic              wrHit, rdHit;

   assign wrHit     = wrEn & wrOwn_q;
   assign rdHit     = rdEn & rdOwn_q;
   assign fullLimit = CW'(DEPTH) - CW'(fullLvl_q);

   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         afRaw[i] = fill_q[i] >= fullLimit;
         aeRaw[i] = fill_q[i] <= CW'(emptyLvl_q);
      end
   end

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cyc_i & stb_i & ~ack_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         skew_q     <= 1'b0;
         fullLvl_q  <= `FULLLVL_RST;
         emptyLvl_q <= `EMPTYLVL_RST;
         iMask_q    <= `IMASK_RST;
      end else if (wbWr) begin
         unique case (adr_i)
            `AF_CTRL_OFS:     if (sel_i[0]) skew_q <= dat_i[`CTRL_SKEW_BIT];
            `AF_FULLLVL_OFS:  fullLvl_q  <= fullMerge[15:0];
            `AF_EMPTYLVL_OFS: emptyLvl_q <= emptyMerge[15:0];
            `AF_IMASK_OFS:    if (sel_i[0]) iMask_q <= dat_i[7:0];
            default: ;
         endcase
      end
   end

   // unmapped addresses answer with zero
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdData_q <= 32'h0;
      end else if (wbRd) begin
         unique case (adr_i)
            `AF_CTRL_OFS:     rdData_q <= {31'h0, skew_q};
            `AF_FULLLVL_OFS:  rdData_q <= {16'h0, fullLvl_q};
            `AF_EMPTYLVL_OFS: rdData_q <= {16'h0, emptyLvl_q};
            `AF_FLAGS_OFS:    rdData_q <= {20'h0, aeBusOwn_q, afBusOwn_q, rdOwn_q,
                                           wrOwn_q, aeStat_q, afStat_q};
            `AF_ISTAT_OFS:    rdData_q <= {24'h0, iStat_q};
            `AF_IMASK_OFS:    rdData_q <= {24'h0, iMask_q};
            default:          rdData_q <= 32'h0;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdData_q;

   // ------------------------------------------------------------
   // interrupts: rising flags, write one to clear, set wins
   // ------------------------------------------------------------
   logic [7:0] iEvent;
   logic [7:0] iClr;

   assign iEvent = {aeD1_q & ~aeStat_q, afD1_q & ~afStat_q} &
                   {nextStat(aeRaw, aeD1_q, skew_q), nextStat(afRaw, afD1_q, skew_q)};
   assign iClr   = (wbWr && adr_i == `AF_ISTAT_OFS && sel_i[0]) ? wrWord[7:0] : 8'h0;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         iStat_q <= 8'h0;
      end else begin
         iStat_q <= (iStat_q & ~iClr) | iEvent;
      end
   end

   assign irq = |(iStat_q & iMask_q);

   // ------------------------------------------------------------
   // port and bus selections
   // ------------------------------------------------------------
   // selects pass one stage first: ownership lags the select edge by one cycle
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wrSelD_q <= '0;
         rdSelD_q <= '0;
         afSelD_q <= '0;
         aeSelD_q <= '0;
      end else begin
         wrSelD_q <= wrSel;
         rdSelD_q <= rdSel;
         afSelD_q <= afBusSel;
         aeSelD_q <= aeBusSel;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wrOwn_q <= 1'b0;
         wrQ_q   <= '0;
         wrQ2_q  <= '0;
      end else begin
         if (wrSelD_q.stb) begin
            wrOwn_q <= wrSelD_q.dev == deviceId;
            wrQ_q   <= wrSelD_q.queue;
         end
         wrQ2_q <= wrQ_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdOwn_q <= 1'b0;
         rdQ_q   <= '0;
         rdQ2_q  <= '0;
      end else begin
         if (rdSelD_q.stb) begin
            rdOwn_q <= rdSelD_q.dev == deviceId;
            rdQ_q   <= rdSelD_q.queue;
         end
         rdQ2_q <= rdQ_q;
      end
   end

   // the master owns both status buses until the first selection
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         afBusOwn_q <= ~flagBusExpansionIn;
         aeBusOwn_q <= ~flagBusExpansionIn;
      end else begin
         if (afSelD_q.stb) afBusOwn_q <= afSelD_q.dev == deviceId;
         if (aeSelD_q.stb) aeBusOwn_q <= aeSelD_q.dev == deviceId;
      end
   end

   // ------------------------------------------------------------
   // queue fill tracking and flag pipeline
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         for (int i = 0; i < NQ; i++) fill_q[i] <= '0;
      end else begin
         for (int i = 0; i < NQ; i++) begin
            if (wrHit && wrQ_q == queue_t'(i) && !(rdHit && rdQ_q == queue_t'(i))) begin
               if (fill_q[i] != CW'(DEPTH)) fill_q[i] <= fill_q[i] + CW'(1);
            end else if (rdHit && rdQ_q == queue_t'(i) && !(wrHit && wrQ_q == queue_t'(i)))
               begin
               if (fill_q[i] != '0) fill_q[i] <= fill_q[i] - CW'(1);
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         afD1_q   <= '0;
         aeD1_q   <= '1;
         afStat_q <= '0;
         aeStat_q <= '1;
      end else begin
         afD1_q   <= afRaw;
         aeD1_q   <= aeRaw;
         afStat_q <= nextStat(afRaw, afD1_q, skew_q);
         aeStat_q <= nextStat(aeRaw, aeD1_q, skew_q);
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   assign almostFullFlagN        = ~afStat_q[wrQ2_q];
   assign almostFullFlagOe       = wrOwn_q;
   assign almostEmptyFlagN       = ~aeStat_q[rdQ2_q];
   assign almostEmptyFlagOe      = rdOwn_q;
   assign readDataOe             = rdOwn_q;
   assign almostFullStatusBusN   = ~afStat_q;
   assign almostFullStatusBusOe  = afBusOwn_q;
   assign almostEmptyStatusBusN  = ~aeStat_q;
   assign almostEmptyStatusBusOe = aeBusOwn_q;
   assign flagBusExpansionOut    = afBusOwn_q | aeBusOwn_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   af_assert_lat_a: assert property (
      ((afStat_q & ~$past(afStat_q)) & ~$past(afRaw, 2)) == '0)
      else $error("almost full rose without level two cycles back");
   af_release_lat_a: assert property (
      !skew_q ##1 !skew_q |-> (afStat_q & ~$past(afRaw)) == '0)
      else $error("almost full held after level dropped");
   ae_assert_lat_a: assert property (
      ((aeStat_q & ~$past(aeStat_q)) & ~$past(aeRaw, 2)) == '0)
      else $error("almost empty rose without level two cycles back");
   ae_skew_hold_a: assert property (
      skew_q |=> aeStat_q == $past(aeRaw, 2))
      else $error("almost empty skew path wrong");
   ae_own_float_a: assert property (
      rdSel.stb && rdSel.dev != deviceId |=> ##1 !almostEmptyFlagOe && !readDataOe)
      else $error("almost empty flag driven without ownership");
   ae_bus_take_a: assert property (
      aeBusSel.stb && aeBusSel.dev == deviceId |=> ##1 almostEmptyStatusBusOe ##0
      almostEmptyStatusBusN == ~aeStat_q)
      else $error("empty status bus not taken one cycle after select");
   af_bus_drop_a: assert property (
      afBusSel.stb && afBusSel.dev != deviceId |=> ##1 !almostFullStatusBusOe)
      else $error("full status bus still driven by old owner");
   af_switch_lat_a: assert property (
      wrSel.stb && wrOwn_q ##1 !wrSel.stb ##1 !wrSel.stb ##1 !wrSel.stb |->
      almostFullFlagN == ~afStat_q[$past(wrSel.queue, 3)])
      else $error("almost full flag not on new queue after two cycles");

   full_flag_c:  cover property ($fell(almostFullFlagN) && almostFullFlagOe);
   empty_flag_c: cover property ($rose(almostEmptyFlagN) ##1 $fell(almostEmptyFlagN));
   bus_swap_c:   cover property ($rose(almostEmptyStatusBusOe) ##[1:8] $fell(almostEmptyStatusBusOe));
   irq_c:        cover property ($rose(irq));
endmodule : multiqueue_almost_flag_logic

// File: logic/almost_flag_map.svh
// register map, field positions and reset values of the almost-flag block
// assumes 32-bit classic wishbone with byte addresses
`ifndef ALMOST_FLAG_MAP_SVH
`define ALMOST_FLAG_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define AF_CTRL_OFS   8'h00
`define AF_FULLLVL_OFS 8'h04
`define AF_EMPTYLVL_OFS 8'h08
`define AF_FLAGS_OFS  8'h0c
`define AF_ISTAT_OFS  8'h10
`define AF_IMASK_OFS  8'h14

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define CTRL_SKEW_BIT 0
`define FULLLVL_RST   16'h0008
`define EMPTYLVL_RST  16'h0008
`define IMASK_RST     8'h00

`endif

// File: logic/almost_flag_pkg.sv
// types shared by the almost-flag block and its surroundings
// assumes up to 8 devices of 4 queues in expansion
package almost_flag_pkg;
   typedef logic [2:0] dev_t;
   typedef logic [1:0] queue_t;

   // one selection request: strobe, device and queue
   typedef struct packed {
      logic   stb;
      dev_t   dev;
      queue_t queue;
   } sel_s;
endpackage : almost_flag_pkg

// File: testbench/flag_host_model.sv
// host board model: resolves the tristate flag pins of one device as the host sees them
// assumes one device on the board and a synchronous host clock
`timescale 1ns/1ps

module flag_host_model #(
   parameter int NQ = 4
) (
   input  wire logic          core_clk,  // host clock
   input  wire logic          afN,       // discrete full flag pin
   input  wire logic          afOe,      // its enable
   input  wire logic          aeN,       // discrete empty flag pin
   input  wire logic          aeOe,      // its enable
   input  wire logic [NQ-1:0] afBusN,    // full status pins
   input  wire logic          afBusOe,   // their enable
   input  wire logic [NQ-1:0] aeBusN,    // empty status pins
   input  wire logic          aeBusOe,   // their enable
   output logic               expIn,     // expansion strap
   output logic               afFlag,    // resolved full flag
   output logic               aeFlag,    // resolved empty flag
   output logic [NQ-1:0]      afBus,     // resolved full bus
   output logic [NQ-1:0]      aeBus      // resolved empty bus
);
   logic          afLast    = 1'b0;
   logic          aeLast    = 1'b0;
   logic [NQ-1:0] afBusLast = '0;
   logic [NQ-1:0] aeBusLast = '0;

   // ------------------------------------------------------------
   // board wiring
   // ------------------------------------------------------------
   // single device is the master of both status buses
   assign expIn  = 1'b0;
   // a released pin shows the inverse of its last level, so stale data never matches
   assign afFlag = afOe ? afN : ~afLast;
   assign aeFlag = aeOe ? aeN : ~aeLast;
   assign afBus  = afBusOe ? afBusN : ~afBusLast;
   assign aeBus  = aeBusOe ? aeBusN : ~aeBusLast;

   always_ff @(posedge core_clk) begin
      if (afOe) afLast <= afN;
      if (aeOe) aeLast <= aeN;
      if (afBusOe) afBusLast <= afBusN;
      if (aeBusOe) aeBusLast <= aeBusN;
   end
endmodule : flag_host_model

// File: testbench/multiqueue_almost_flag_logic_test.sv
// self-checking bench of the almost-flag block: wishbone tasks, port strobes, selects
// assumes the host model above resolves the tristate pins; device number 1
`timescale 1ns/1ps
`include "almost_flag_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module multiqueue_almost_flag_logic_test;
   import almost_flag_pkg::*;
   localparam int NQ    = 4;
   localparam int DEPTH = 32;
   logic core_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wrData = 32'h0, rdData, q;
   logic ack, irq, expIn, expOut, afN, afOe, aeN, aeOe, readDataOe, afBusOe, aeBusOe;
   logic afFlag, aeFlag, wrEn = 1'b0, rdEn = 1'b0;
   logic [NQ-1:0] afBusN, aeBusN, afBus, aeBus;
   sel_s wrSel = '0, rdSel = '0, afSel = '0, aeSel = '0;
   int checks = 0, miscompares = 0;

   multiqueue_almost_flag_logic #(.NQ(NQ), .DEPTH(DEPTH)) DUT (.core_clk(core_clk),
      .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wrData), .dat_o(rdData), .ack_o(ack), .irq(irq), .deviceId(3'h1),
      .flagBusExpansionIn(expIn), .flagBusExpansionOut(expOut), .wrSel(wrSel),
      .rdSel(rdSel), .afBusSel(afSel), .aeBusSel(aeSel), .wrEn(wrEn), .rdEn(rdEn),
      .almostFullFlagN(afN), .almostFullFlagOe(afOe), .almostEmptyFlagN(aeN),
      .almostEmptyFlagOe(aeOe), .readDataOe(readDataOe), .almostFullStatusBusN(afBusN),
      .almostFullStatusBusOe(afBusOe), .almostEmptyStatusBusN(aeBusN),
      .almostEmptyStatusBusOe(aeBusOe));
   flag_host_model #(.NQ(NQ)) host (.core_clk(core_clk), .afN(afN), .afOe(afOe),
      .aeN(aeN), .aeOe(aeOe), .afBusN(afBusN), .afBusOe(afBusOe), .aeBusN(aeBusN),
      .aeBusOe(aeBusOe), .expIn(expIn), .afFlag(afFlag), .aeFlag(aeFlag),
      .afBus(afBus), .aeBus(aeBus));

   initial begin
      forever #50 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      {cyc, stb, we, adr, wrData, sel} <= {2'b11, w, a, d, 4'hf};
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdData;
      {cyc, stb, we} <= 3'b000;
      if (n >= 20) begin
         miscompares++;
         finish_test();
      end
   endtask : wb

   // word strobes held for cnt edges; returns at the last sampling edge
   task automatic burst(input logic w, input logic r, input int cnt);
      @(posedge core_clk);
      {wrEn, rdEn} <= {w, r};
      repeat (cnt) @(posedge core_clk);
      {wrEn, rdEn} <= 2'b00;
   endtask : burst

   task automatic choose(input int k, input dev_t d, input queue_t qu);
      @(posedge core_clk);
      case (k)
         0: wrSel <= '{1'b1, d, qu};
         1: rdSel <= '{1'b1, d, qu};
         2: afSel <= '{1'b1, d, qu};
         default: aeSel <= '{1'b1, d, qu};
      endcase
      @(posedge core_clk);
      {wrSel.stb, rdSel.stb, afSel.stb, aeSel.stb} <= 4'h0;
   endtask : choose

   function automatic logic probe(input int k);
      case (k)
         0: probe = afFlag;
         1: probe = aeFlag;
         2: probe = afBus[1];
         3: probe = afOe;
         4: probe = aeOe;
         5: probe = aeBusOe;
         default: probe = afBusOe;
      endcase
   endfunction : probe

   // old level up to the edge before n, new level from edge n after the strobe edge
   task automatic lat(input string nm, input int k, input int n, input logic v);
      #1;
      for (int i = 0; i <= n; i++) begin
         if (i > 0) begin
            @(posedge core_clk);
            #1;
         end
         `CHK(nm, (i < n) ? ~v : v, probe(k))
      end
   endtask : lat

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      wb(1'b0, `AF_FULLLVL_OFS, 32'h0);
      `CHK("fulllvl", `FULLLVL_RST, q[15:0])
      wb(1'b0, `AF_EMPTYLVL_OFS, 32'h0);
      `CHK("emptylvl", `EMPTYLVL_RST, q[15:0])
      wb(1'b0, `AF_IMASK_OFS, 32'h0);
      `CHK("imask", `IMASK_RST, q[7:0])
      wb(1'b0, `AF_FLAGS_OFS, 32'h0);
      `CHK("flags", 12'hcf0, q[11:0])
      wb(1'b1, 8'h1c, 32'hffff_ffff);
      wb(1'b0, 8'h1c, 32'h0);
      `CHK("unmapped", 32'h0, q)
      $display("test registers done");
      choose(0, 3'h1, 2'h1);
      lat("wr own", 3, 1, 1'b1);
      choose(1, 3'h1, 2'h1);
      lat("rd own", 4, 1, 1'b1);
      `CHK("data oe", 1'b1, readDataOe)
      lat("rd flag", 1, 0, 1'b0);
      burst(1'b1, 1'b0, 8);
      burst(1'b1, 1'b0, 1);
      lat("ae release", 1, 1, 1'b1);
      burst(1'b0, 1'b1, 1);
      lat("ae assert", 1, 2, 1'b0);
      burst(1'b1, 1'b0, 16);
      lat("af assert", 0, 2, 1'b0);
      `CHK("af bus", 4'hd, afBus)
      `CHK("ae bus", 4'h2, aeBus)
      burst(1'b0, 1'b1, 1);
      lat("af release", 0, 1, 1'b1);
      `CHK("af bus bit", 1'b1, afBus[1])
      burst(1'b1, 1'b0, 1);
      wb(1'b1, `AF_CTRL_OFS, 32'h1);
      burst(1'b0, 1'b1, 1);
      lat("af skew", 2, 2, 1'b1);
      burst(1'b1, 1'b0, 1);
      $display("test flag latency done");
      repeat (3) @(posedge core_clk);
      #1;
      `CHK("irq masked", 1'b0, irq)
      wb(1'b0, `AF_ISTAT_OFS, 32'h0);
      `CHK("istat", 8'h22, q[7:0])
      wb(1'b1, `AF_IMASK_OFS, 32'h2);
      repeat (2) @(posedge core_clk);
      `CHK("irq on", 1'b1, irq)
      wb(1'b1, `AF_ISTAT_OFS, 32'hff);
      repeat (2) @(posedge core_clk);
      `CHK("irq off", 1'b0, irq)
      $display("test interrupt done");
      choose(0, 3'h1, 2'h0);
      lat("wr switch", 0, 2, 1'b1);
      choose(1, 3'h1, 2'h0);
      lat("rd switch", 1, 2, 1'b0);
      choose(1, 3'h1, 2'h1);
      lat("rd back", 1, 2, 1'b1);
      choose(1, 3'h2, 2'h0);
      lat("rd release", 4, 1, 1'b0);
      `CHK("data off", 1'b0, readDataOe)
      choose(3, 3'h2, 2'h0);
      lat("ae bus off", 5, 1, 1'b0);
      choose(2, 3'h2, 2'h0);
      lat("af bus off", 6, 1, 1'b0);
      @(posedge core_clk);
      #1;
      `CHK("exp out", 1'b0, expOut)
      choose(2, 3'h1, 2'h0);
      lat("af bus on", 6, 1, 1'b1);
      choose(3, 3'h1, 2'h0);
      lat("ae bus on", 5, 1, 1'b1);
      `CHK("ae bus back", 4'h2, aeBus)
      $display("test expansion done");
      finish_test();
   end
endmodule : multiqueue_almost_flag_logic_test
